// file: siwcc_consts.svh
// Register map, field positions and reset values of the serial wire/clock control
// Assumes inclusion by bare name from every design file that needs them
`ifndef SIWCC_CONSTS_SVH
`define SIWCC_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SIWCC_OFS_CTRL   8'h00
`define SIWCC_OFS_STAT   8'h04
`define SIWCC_OFS_DATA   8'h08
`define SIWCC_OFS_PINPOS 8'h0C
`define SIWCC_OFS_PORT_A_OUTPUT  8'h10
`define SIWCC_OFS_PORTB  8'h14
`define SIWCC_OFS_MASK   8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define SIWCC_CTRL_WM_LO  4
`define SIWCC_CTRL_CS_LO  2
`define SIWCC_CTRL_STROBE 1
`define SIWCC_CTRL_TOGGLE 0
`define SIWCC_ST_START    7
`define SIWCC_ST_OVF      6
`define SIWCC_PORT_DIR_LO 4
`define SIWCC_PIN_DI      0
`define SIWCC_PIN_DO      1
`define SIWCC_PIN_SCK     2

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define SIWCC_WM_OFF      2'h0
`define SIWCC_WM_THREE    2'h1
`define SIWCC_WM_TWO_OVF  2'h3
`define SIWCC_CS_SOFT     2'h0
`define SIWCC_CS_TIMER    2'h1
`define SIWCC_CNT_MAX     4'hF
`define SIWCC_RST_BYTE    8'h00
`define SIWCC_RST_PIN3    3'h0
`define SIWCC_PIN_IDLE    3'h7
`define SIWCC_RESP_OKAY   2'h0
`define SIWCC_RESP_SLVERR 2'h2

`endif

// file: siwcc_peer.sv
// Peer on the serial bus: pulls data and clock low, runs clock frames
// Assumes bus pull-ups, so a released line reads high
`timescale 1ns/1ps

module siwcc_peer (
	// Device drive of the routed pins
	input  wire logic [2:0] i_pin_out,
	input  wire logic [2:0] i_pin_oe,
	// Peer commands
	input  wire logic       i_sda_low,
	input  wire logic       i_go,
	input  wire logic [3:0] i_periods,
	// Resolved line levels
	output logic      [2:0] o_line
);
	// ****************************************************************
	// Link clock, still outside frames
	// ****************************************************************
	logic       scl_low;
	logic [2:0] drv;

	initial scl_low = 1'b0;
	always @(posedge i_go) begin
		repeat (i_periods) begin
			scl_low = 1'b1;
			#62.5;
			scl_low = 1'b0;
			#62.5;
		end
	end

	// ****************************************************************
	// Wired levels of the three pins
	// ****************************************************************
	assign drv    = (i_pin_oe & i_pin_out) | ~i_pin_oe;
	assign o_line = drv & {~scl_low, 1'b1, ~i_sda_low};
endmodule

// file: siwcc_pkg.sv
// Shared types of the serial wire/clock control
// Assumes nothing beyond a SystemVerilog compiler
package siwcc_pkg;
	typedef logic [7:0] siwcc_byte_t;
	typedef logic [2:0] siwcc_pins_t;
	typedef logic [1:0] siwcc_resp_t;
endpackage

// file: siwcc_top.sv
// Two-wire drive, clock source selection and pin routing of a universal serial iface
// Assumes an AXI4-Lite master on I_CORE_CLK and port pins that are asynchronous
//
// What this block does
// - Mode 10: data and clock pins open-drain, drivers enabled by routed port direction.
// - Two-wire data pin pulled low when output latch or port bit is zero.
// - Two-wire clock pin pulled low when port bit zero or start hold.
// - Start condition with clock output enabled holds clock low until flag cleared.
// - Two-wire mode disables data and clock pull-ups; input sampling unchanged.
// - Mode 11 also holds clock low from counter overflow until flag cleared.
// - External clock: output latch updates on edge opposite to data sampling.
// - Strobe or timer clock: output latch transparent, output follows shifts.
// - Source 00: strobe bit clocks shifter and counter; 01: timer match clocks both.
// - External: shifter on rising or falling edge; counter both edges or toggle writes.
// - Strobe shifts once, counts once, shifts in earlier sample; strobe reads zero.
// - Toggle write inverts clock port output bit; toggle reads zero.
// - External source with strobe bit set: each toggle write increments counter.
// - Pin position bit 0 routes functions to port B low pins or port A low pins.
// - Pin position bits 7 to 1 read as zero.
// - Start flag set on two-wire start, cleared only by writing one.
// - Overflow flag set when counter wraps 15 to 0, cleared only by writing one.
`timescale 1ns/1ps
`include "siwcc_consts.svh"

module siwcc_top
	import siwcc_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	// AXI4-Lite write
	input  wire logic [7:0]  I_AWADDR,
	input  wire logic        I_AWVALID,
	output logic             O_AWREADY,
	input  wire logic [31:0] I_WDATA,
	input  wire logic [3:0]  I_WSTRB,
	input  wire logic        I_WVALID,
	output logic             O_WREADY,
	output logic [1:0]       O_BRESP,
	output logic             O_BVALID,
	input  wire logic        I_BREADY,
	// AXI4-Lite read
	input  wire logic [7:0]  I_ARADDR,
	input  wire logic        I_ARVALID,
	output logic             O_ARREADY,
	output logic [31:0]      O_RDATA,
	output logic [1:0]       O_RRESP,
	output logic             O_RVALID,
	input  wire logic        I_RREADY,
	// Timer compare match pulse
	input  wire logic        I_TIMER0_MATCH,
	// Port A low pins
	input  wire logic [2:0]  I_PA_IN,
	output logic [2:0]       O_PA_OUT,
	output logic [2:0]       O_PA_OE,
	output logic [2:0]       O_PA_PULLUP,
	// Port B low pins
	input  wire logic [2:0]  I_PB_IN,
	output logic [2:0]       O_PB_OUT,
	output logic [2:0]       O_PB_OE,
	output logic [2:0]       O_PB_PULLUP,
	// Interrupt
	output logic             O_IRQ
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [1:0]  wire_mode_select;
	logic [1:0]  clock_source_select;
	logic        ext_cnt_sel;
	siwcc_byte_t shreg;
	logic [3:0]  cnt;
	logic        start_condition_flag;
	logic        counter_overflow_flag;
	logic [1:0]  irq_mask;
	logic        pin_position_select;
	siwcc_pins_t port_a_output;
	siwcc_pins_t port_a_direction;
	siwcc_pins_t port_b_output;
	siwcc_pins_t port_b_direction;
	siwcc_pins_t pa_s1;
	siwcc_pins_t pa_s2;
	siwcc_pins_t pb_s1;
	siwcc_pins_t pb_s2;
	logic        scl_d;
	logic        sda_d;
	logic        di_prev;
	logic        do_latch;
	siwcc_pins_t sel_out;
	siwcc_pins_t sel_dir;
	siwcc_pins_t sel_in;
	siwcc_pins_t fn_out;
	siwcc_pins_t fn_oe;
	siwcc_pins_t fn_pu;
	logic        two_wire;
	logic        wr_fire;
	logic        wr_ctrl;
	logic        wr_stat;
	logic        wr_data;
	logic        strobe_sw;
	logic        toggle_wr;
	logic        scl_rise;
	logic        scl_fall;
	logic        shift_en;
	logic        cnt_en;
	logic        start_det;
	logic        clr_start;
	logic        clr_ovf;
	logic        clk_hold;
	logic        data_out;
	logic        wr_hit;
	logic        rd_hit;
	siwcc_byte_t rd_byte;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	assign O_AWREADY = I_AWVALID & I_WVALID & ~O_BVALID;
	assign O_WREADY  = O_AWREADY;
	assign O_ARREADY = ~O_RVALID;
	assign wr_fire   = O_AWREADY;
	assign wr_hit    = (I_AWADDR == `SIWCC_OFS_CTRL) | (I_AWADDR == `SIWCC_OFS_STAT)
		| (I_AWADDR == `SIWCC_OFS_DATA) | (I_AWADDR == `SIWCC_OFS_PINPOS)
		| (I_AWADDR == `SIWCC_OFS_PORT_A_OUTPUT) | (I_AWADDR == `SIWCC_OFS_PORTB)
		| (I_AWADDR == `SIWCC_OFS_MASK);
	assign wr_ctrl   = wr_fire & I_WSTRB[0] & (I_AWADDR == `SIWCC_OFS_CTRL);
	assign wr_stat   = wr_fire & I_WSTRB[0] & (I_AWADDR == `SIWCC_OFS_STAT);
	assign wr_data   = wr_fire & I_WSTRB[0] & (I_AWADDR == `SIWCC_OFS_DATA);

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_BVALID <= 1'b0;
			O_BRESP  <= `SIWCC_RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP  <= wr_hit ? `SIWCC_RESP_OKAY : `SIWCC_RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = `SIWCC_RST_BYTE;
		unique case (I_ARADDR)
			`SIWCC_OFS_CTRL:   rd_byte = {2'b00, wire_mode_select, clock_source_select, 2'b00};
			`SIWCC_OFS_STAT:   rd_byte = {start_condition_flag, counter_overflow_flag, 2'b00, cnt};
			`SIWCC_OFS_DATA:   rd_byte = shreg;
			`SIWCC_OFS_PINPOS: rd_byte = {7'h00, pin_position_select};
			`SIWCC_OFS_PORT_A_OUTPUT:  rd_byte = {1'b0, port_a_direction, 1'b0, port_a_output};
			`SIWCC_OFS_PORTB:  rd_byte = {1'b0, port_b_direction, 1'b0, port_b_output};
			`SIWCC_OFS_MASK:   rd_byte = {irq_mask, 6'h00};
			default:           rd_hit  = 1'b0;
		endcase
	end

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RVALID <= 1'b0;
			O_RDATA  <= 32'h0000_0000;
			O_RRESP  <= `SIWCC_RESP_OKAY;
		end else if (I_ARVALID & O_ARREADY) begin
			O_RVALID <= 1'b1;
			O_RDATA  <= {24'h00_0000, rd_byte};
			O_RRESP  <= rd_hit ? `SIWCC_RESP_OKAY : `SIWCC_RESP_SLVERR;
		end else if (I_RREADY) begin
			O_RVALID <= 1'b0;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			wire_mode_select    <= `SIWCC_WM_OFF;
			clock_source_select <= `SIWCC_CS_SOFT;
			ext_cnt_sel         <= 1'b0;
			irq_mask            <= 2'b00;
			pin_position_select <= 1'b0;
		end else if (wr_fire & I_WSTRB[0]) begin
			if (I_AWADDR == `SIWCC_OFS_CTRL) begin
				wire_mode_select    <= I_WDATA[`SIWCC_CTRL_WM_LO +: 2];
				clock_source_select <= I_WDATA[`SIWCC_CTRL_CS_LO +: 2];
				ext_cnt_sel         <= I_WDATA[`SIWCC_CTRL_STROBE];
			end
			if (I_AWADDR == `SIWCC_OFS_MASK) begin
				irq_mask <= I_WDATA[`SIWCC_ST_OVF +: 2];
			end
			if (I_AWADDR == `SIWCC_OFS_PINPOS) begin
				pin_position_select <= I_WDATA[0];
			end
		end
	end

	// Port registers; toggle inverts the clock bit of the routed port
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			port_a_output    <= `SIWCC_RST_PIN3;
			port_a_direction <= `SIWCC_RST_PIN3;
			port_b_output    <= `SIWCC_RST_PIN3;
			port_b_direction <= `SIWCC_RST_PIN3;
		end else begin
			if (wr_fire & I_WSTRB[0] & (I_AWADDR == `SIWCC_OFS_PORT_A_OUTPUT)) begin
				port_a_output    <= I_WDATA[2:0];
				port_a_direction <= I_WDATA[`SIWCC_PORT_DIR_LO +: 3];
			end else if (toggle_wr & pin_position_select) begin
				port_a_output[`SIWCC_PIN_SCK] <= ~port_a_output[`SIWCC_PIN_SCK];
			end
			if (wr_fire & I_WSTRB[0] & (I_AWADDR == `SIWCC_OFS_PORTB)) begin
				port_b_output    <= I_WDATA[2:0];
				port_b_direction <= I_WDATA[`SIWCC_PORT_DIR_LO +: 3];
			end else if (toggle_wr & ~pin_position_select) begin
				port_b_output[`SIWCC_PIN_SCK] <= ~port_b_output[`SIWCC_PIN_SCK];
			end
		end
	end

	// ****************************************************************
	// Pin input synchronisers and edge detection
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			pa_s1 <= `SIWCC_PIN_IDLE;
			pa_s2 <= `SIWCC_PIN_IDLE;
			pb_s1 <= `SIWCC_PIN_IDLE;
			pb_s2 <= `SIWCC_PIN_IDLE;
		end else begin
			pa_s1 <= I_PA_IN;
			pa_s2 <= pa_s1;
			pb_s1 <= I_PB_IN;
			pb_s2 <= pb_s1;
		end
	end

	assign sel_in  = pin_position_select ? pa_s2 : pb_s2;
	assign sel_out = pin_position_select ? port_a_output : port_b_output;
	assign sel_dir = pin_position_select ? port_a_direction : port_b_direction;

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			scl_d   <= 1'b1;
			sda_d   <= 1'b1;
			di_prev <= 1'b0;
		end else begin
			scl_d   <= sel_in[`SIWCC_PIN_SCK];
			sda_d   <= sel_in[`SIWCC_PIN_DI];
			di_prev <= sel_in[`SIWCC_PIN_DI];
		end
	end

	assign scl_rise  = sel_in[`SIWCC_PIN_SCK] & ~scl_d;
	assign scl_fall  = ~sel_in[`SIWCC_PIN_SCK] & scl_d;
	assign two_wire  = wire_mode_select[1];
	assign start_det = two_wire & sda_d & ~sel_in[`SIWCC_PIN_DI] & scl_d & sel_in[`SIWCC_PIN_SCK];

	// ****************************************************************
	// Clock source selection
	// ****************************************************************
	assign strobe_sw = wr_ctrl & I_WDATA[`SIWCC_CTRL_STROBE]
		& (I_WDATA[`SIWCC_CTRL_CS_LO +: 2] == `SIWCC_CS_SOFT);
	assign toggle_wr = wr_ctrl & I_WDATA[`SIWCC_CTRL_TOGGLE];
	assign shift_en  = strobe_sw
		| ((clock_source_select == `SIWCC_CS_TIMER) & I_TIMER0_MATCH)
		| (clock_source_select[1] & (clock_source_select[0] ? scl_fall : scl_rise));
	assign cnt_en    = strobe_sw
		| ((clock_source_select == `SIWCC_CS_TIMER) & I_TIMER0_MATCH)
		| (clock_source_select[1] & ~ext_cnt_sel & (scl_rise | scl_fall))
		| (clock_source_select[1] & ext_cnt_sel & toggle_wr);

	// ****************************************************************
	// Shifter, output latch and counter
	// ****************************************************************
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			shreg <= `SIWCC_RST_BYTE;
		end else if (wr_data) begin
			shreg <= I_WDATA[7:0];
		end else if (shift_en) begin
			shreg <= {shreg[6:0], di_prev};
		end
	end

	// Latch follows MSB on the edge opposite to sampling
	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			do_latch <= 1'b0;
		end else if (clock_source_select[1] & (clock_source_select[0] ? scl_rise : scl_fall)) begin
			do_latch <= shreg[7];
		end
	end

	assign data_out = clock_source_select[1] ? do_latch : shreg[7];

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			cnt <= 4'h0;
		end else if (wr_stat) begin
			cnt <= I_WDATA[3:0];
		end else if (cnt_en) begin
			cnt <= cnt + 4'h1;
		end
	end

	// ****************************************************************
	// Sticky flags and interrupt
	// ****************************************************************
	assign clr_start = wr_stat & I_WDATA[`SIWCC_ST_START];
	assign clr_ovf   = wr_stat & I_WDATA[`SIWCC_ST_OVF];

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			start_condition_flag <= 1'b0;
		end else if (start_det) begin
			start_condition_flag <= 1'b1;
		end else if (clr_start) begin
			start_condition_flag <= 1'b0;
		end
	end

	always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
		if (I_RST) begin
			counter_overflow_flag <= 1'b0;
		end else if (cnt_en & ~wr_stat & (cnt == `SIWCC_CNT_MAX)) begin
			counter_overflow_flag <= 1'b1;
		end else if (clr_ovf) begin
			counter_overflow_flag <= 1'b0;
		end
	end

	assign O_IRQ = |({start_condition_flag, counter_overflow_flag} & irq_mask);

	// ****************************************************************
	// Pin function override
	// ****************************************************************
	assign clk_hold = (two_wire & start_condition_flag)
		| ((wire_mode_select == `SIWCC_WM_TWO_OVF) & counter_overflow_flag);

	always_comb begin
		fn_out = sel_out;
		fn_oe  = sel_dir;
		fn_pu  = ~sel_dir & sel_out;
		if (wire_mode_select == `SIWCC_WM_THREE) begin
			fn_out[`SIWCC_PIN_DO] = data_out;
		end
		if (two_wire) begin
			fn_out[`SIWCC_PIN_DI]  = 1'b0;
			fn_out[`SIWCC_PIN_SCK] = 1'b0;
			fn_oe[`SIWCC_PIN_DI]   = sel_dir[`SIWCC_PIN_DI]
				& (~data_out | ~sel_out[`SIWCC_PIN_DI]);
			fn_oe[`SIWCC_PIN_SCK]  = sel_dir[`SIWCC_PIN_SCK]
				& (~sel_out[`SIWCC_PIN_SCK] | clk_hold);
			fn_pu[`SIWCC_PIN_DI]   = 1'b0;
			fn_pu[`SIWCC_PIN_SCK]  = 1'b0;
		end
	end

	assign O_PA_OUT    = pin_position_select ? fn_out : port_a_output;
	assign O_PA_OE     = pin_position_select ? fn_oe : port_a_direction;
	assign O_PA_PULLUP = pin_position_select ? fn_pu : (~port_a_direction & port_a_output);
	assign O_PB_OUT    = pin_position_select ? port_b_output : fn_out;
	assign O_PB_OE     = pin_position_select ? port_b_direction : fn_oe;
	assign O_PB_PULLUP = pin_position_select ? (~port_b_direction & port_b_output) : fn_pu;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	sda_pull_a: assert property (two_wire & sel_dir[0] & ~data_out |-> fn_oe[0] & ~fn_out[0])
		else $error("data pin not pulled low");
	start_hold_a: assert property ($rose(start_condition_flag) & two_wire & sel_dir[2]
		|-> fn_oe[2] && !fn_out[2])
		else $error("clock not held after start");
	ovf_hold_a: assert property (wire_mode_select == `SIWCC_WM_TWO_OVF && counter_overflow_flag
		&& sel_dir[2] |-> fn_oe[2])
		else $error("clock not held on overflow");
	ovf_set_a: assert property (cnt_en && !wr_stat && cnt == `SIWCC_CNT_MAX
		|=> counter_overflow_flag && cnt == 4'h0)
		else $error("overflow not flagged on wrap");
	start_sticky_a: assert property (start_condition_flag && !clr_start |=> start_condition_flag)
		else $error("start flag dropped without write");
	strobe_shift_a: assert property (strobe_sw && !wr_data
		|=> shreg == {$past(shreg[6:0]), $past(di_prev)})
		else $error("strobe shift wrong");
	toggle_cnt_a: assert property (toggle_wr && ext_cnt_sel && clock_source_select[1]
		&& !wr_stat && !scl_rise && !scl_fall |=> cnt == $past(cnt) + 4'h1)
		else $error("toggle did not count");
	latch_hold_a: assert property (clock_source_select[1] && !scl_rise && !scl_fall
		|=> $stable(do_latch))
		else $error("latch moved off edge");
	pullup_off_a: assert property (two_wire |-> !fn_pu[0] && !fn_pu[2])
		else $error("pull-up on in two-wire");
	toggle_pin_a: assert property (toggle_wr && !pin_position_select
		|=> port_b_output[`SIWCC_PIN_SCK] != $past(port_b_output[`SIWCC_PIN_SCK]))
		else $error("toggle did not invert");

endmodule

// file: siwcc_top_tb.sv
// Self-checking bench of the serial wire/clock control
// Assumes the design files and a bus peer model on port B
`timescale 1ns/1ps
`include "siwcc_consts.svh"

module siwcc_top_tb;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic        clk, rst, awv, wv, bry, arv, rry, tmr, sda_low, go;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdata, rval;
	logic [3:0]  per;
	logic        awrdy, wrdy, bvalid, arrdy, rvalid, irq;
	logic [1:0]  bresp, rresp, wresp, rresp_seen;
	logic [2:0]  pa_in, pa_out, pa_oe, pa_pu, pb_line, pb_out, pb_oe, pb_pu;
	int          n_errors, cmp_count, cycles;
	localparam logic [7:0] ctl = `SIWCC_OFS_CTRL;
	localparam logic [7:0] sts = `SIWCC_OFS_STAT;
	localparam logic [7:0] dat = `SIWCC_OFS_DATA;
	localparam logic [7:0] pps = `SIWCC_OFS_PINPOS;
	localparam logic [7:0] pta = `SIWCC_OFS_PORT_A_OUTPUT;
	localparam logic [7:0] ptb = `SIWCC_OFS_PORTB;
	localparam logic [7:0] msk = `SIWCC_OFS_MASK;
	localparam logic [7:0] offs [7] = '{ctl, sts, dat, pps, pta, ptb, msk};

	assign pa_in = (pa_oe & pa_out) | ~pa_oe;

	siwcc_top dut (.I_CORE_CLK(clk), .I_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
		.O_AWREADY(awrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy),
		.O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bry), .I_ARADDR(ara),
		.I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rry), .I_TIMER0_MATCH(tmr), .I_PA_IN(pa_in),
		.O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .O_PA_PULLUP(pa_pu), .I_PB_IN(pb_line),
		.O_PB_OUT(pb_out), .O_PB_OE(pb_oe), .O_PB_PULLUP(pb_pu), .O_IRQ(irq));

	siwcc_peer peer (.i_pin_out(pb_out), .i_pin_oe(pb_oe), .i_sda_low(sda_low),
		.i_go(go), .i_periods(per), .o_line(pb_line));

	always #2.5 clk = ~clk;

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		awa <= a;
		wd  <= {24'h00_0000, d};
		awv <= 1'b1;
		wv  <= 1'b1;
		bry <= 1'b1;
		do @(negedge clk); while (awrdy !== 1'b1 || wrdy !== 1'b1);
		@(posedge clk);
		awv <= 1'b0;
		wv  <= 1'b0;
		do @(negedge clk); while (bvalid !== 1'b1);
		wresp = bresp;
		@(posedge clk);
		bry <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(negedge clk); while (arrdy !== 1'b1);
		@(posedge clk);
		arv <= 1'b0;
		do @(negedge clk); while (rvalid !== 1'b1);
		rval       = rdata;
		rresp_seen = rresp;
		@(posedge clk);
		rry <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(rval, {24'h00_0000, e});
	endtask

	task automatic pulse();
		@(posedge clk);
		tmr <= 1'b1;
		@(posedge clk);
		tmr <= 1'b0;
	endtask

	task automatic frame(input logic [3:0] n);
		@(posedge clk);
		per <= n;
		go  <= 1'b1;
		@(posedge clk);
		go  <= 1'b0;
		repeat (25 * n + 10) @(posedge clk);
	endtask

	task automatic settle();
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, far above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{clk, rst, awv, wv, bry, arv, rry, tmr, sda_low, go} = 10'h100;
		{awa, ara, wd, per} = '0;
		{n_errors, cmp_count, cycles} = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (offs[i]) rc(offs[i], 8'h00);
		wr(pps, 8'hFF);
		rc(pps, 8'h01);
		wr(pps, 8'h00);
		rd(8'h1C);
		chk(32'(rresp_seen), 32'(`SIWCC_RESP_SLVERR));
		wr(8'h1C, 8'h01);
		chk(32'(wresp), 32'(`SIWCC_RESP_SLVERR));
		// Software strobe and timer clocking
		wr(dat, 8'h81);
		wr(ctl, 8'h02);
		rc(dat, 8'h03);
		rc(sts, 8'h01);
		rc(ctl, 8'h00);
		wr(ctl, 8'h00);
		pulse();
		rc(dat, 8'h03);
		wr(ctl, 8'h04);
		pulse();
		rc(dat, 8'h07);
		rc(sts, 8'h02);
		// Overflow flag and interrupt
		wr(sts, 8'h0F);
		wr(ctl, 8'h02);
		rc(sts, 8'h40);
		wr(msk, 8'h40);
		@(negedge clk);
		chk(32'(irq), 32'h0000_0001);
		wr(msk, 8'h00);
		@(negedge clk);
		chk(32'(irq), 32'h0000_0000);
		wr(msk, 8'h40);
		wr(sts, 8'h40);
		rc(sts, 8'h00);
		chk(32'(irq), 32'h0000_0000);
		// Two-wire drive
		wr(dat, 8'hFF);
		wr(ptb, 8'h07);
		wr(ctl, 8'h20);
		settle();
		chk(32'(pb_pu), 32'h0000_0002);
		chk(32'(pb_oe), 32'h0000_0000);
		wr(ptb, 8'h57);
		settle();
		chk(32'(pb_line), 32'h0000_0007);
		wr(ptb, 8'h53);
		settle();
		chk(32'(pb_line[2]), 32'h0000_0000);
		wr(dat, 8'h7F);
		settle();
		chk(32'(pb_line[0]), 32'h0000_0000);
		wr(dat, 8'hFF);
		wr(ptb, 8'h52);
		settle();
		chk(32'(pb_line[0]), 32'h0000_0000);
		wr(ptb, 8'h53);
		wr(ctl, 8'h21);
		rc(ptb, 8'h57);
		settle();
		chk(32'(pb_line), 32'h0000_0007);
		// Start condition hold
		sda_low <= 1'b1;
		settle();
		rc(sts, 8'h80);
		chk(32'(pb_line[2]), 32'h0000_0000);
		wr(msk, 8'h80);
		@(negedge clk);
		chk(32'(irq), 32'h0000_0001);
		sda_low <= 1'b0;
		wr(sts, 8'h80);
		settle();
		chk(32'(pb_line[2]), 32'h0000_0001);
		rc(sts, 8'h00);
		// Overflow hold in mode 11
		wr(sts, 8'h0F);
		wr(ctl, 8'h32);
		settle();
		rc(sts, 8'h40);
		chk(32'(pb_line[2]), 32'h0000_0000);
		wr(sts, 8'h40);
		settle();
		chk(32'(pb_line[2]), 32'h0000_0001);
		// Transparent output latch
		wr(ptb, 8'h20);
		wr(ctl, 8'h10);
		wr(dat, 8'h80);
		@(negedge clk);
		chk(32'(pb_out[1]), 32'h0000_0001);
		wr(ctl, 8'h12);
		@(negedge clk);
		chk(32'(pb_out[1]), 32'h0000_0000);
		// External clock from the peer
		wr(ptb, 8'h00);
		wr(ctl, 8'h08);
		wr(dat, 8'h00);
		wr(sts, 8'h00);
		frame(4'h4);
		rc(dat, 8'h0F);
		rc(sts, 8'h08);
		wr(ctl, 8'h0C);
		wr(dat, 8'h00);
		wr(sts, 8'h00);
		frame(4'h3);
		rc(dat, 8'h07);
		rc(sts, 8'h06);
		wr(ctl, 8'h0A);
		wr(sts, 8'h00);
		frame(4'h2);
		rc(sts, 8'h00);
		repeat (3) wr(ctl, 8'h0B);
		rc(sts, 8'h03);
		// Pin position
		wr(pps, 8'h01);
		wr(pta, 8'h57);
		wr(ptb, 8'h57);
		wr(ctl, 8'h20);
		wr(dat, 8'h00);
		settle();
		chk(32'(pa_in[0]), 32'h0000_0000);
		chk(32'(pb_line[0]), 32'h0000_0001);
		chk(32'(pa_pu), 32'h0000_0002);
		complete_run();
	end
endmodule
